// ===== hip_ack_timer.sv
// Acknowledge delay timer that builds the internal strobe in pulsed mode.
module hip_ack_timer (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    hip_tmr_if.tmr     tmr
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    hip_pkg::hip_tmr_state_t     state_r;
    logic [hip_pkg::TC_W-1:0]    cnt_r;
    logic [hip_pkg::TC_W-1:0]    tc_eff;
    hip_pkg::hip_duty_t          duty;

    // A zero time constant would never expire, so it acts as one cycle.
    assign tc_eff = (tmr.time_constant == '0) ? hip_pkg::TC_ONE
                                              : tmr.time_constant;
    assign duty   = hip_pkg::hip_duty_t'(tmr.duty);

    // Internal acknowledge is low only in the low phase.
    assign tmr.ack_int_n = (state_r != hip_pkg::HIP_TMR_LOW);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Triggers while busy are ignored; retriggering would stretch the
    // strobe without bound if the source chatters.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= hip_pkg::HIP_TMR_IDLE;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                hip_pkg::HIP_TMR_IDLE: begin
                    if (tmr.trigger) begin
                        cnt_r <= tc_eff;
                        if (duty == hip_pkg::HIP_DUTY_ONE_SHOT) begin
                            state_r <= hip_pkg::HIP_TMR_LOW;
                        end else begin
                            state_r <= hip_pkg::HIP_TMR_DELAY;
                        end
                    end
                end
                hip_pkg::HIP_TMR_DELAY: begin
                    if (cnt_r == hip_pkg::TC_ONE) begin
                        state_r <= hip_pkg::HIP_TMR_LOW;
                        if (duty == hip_pkg::HIP_DUTY_SQUARE) begin
                            cnt_r <= tc_eff;
                        end else begin
                            cnt_r <= hip_pkg::TC_ONE;
                        end
                    end else begin
                        cnt_r <= cnt_r - hip_pkg::TC_ONE;
                    end
                end
                hip_pkg::HIP_TMR_LOW: begin
                    if (cnt_r == hip_pkg::TC_ONE) begin
                        state_r <= hip_pkg::HIP_TMR_IDLE;
                    end else begin
                        cnt_r <= cnt_r - hip_pkg::TC_ONE;
                    end
                end
                default: begin
                    state_r <= hip_pkg::HIP_TMR_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== hip_input_port.sv
// Handshake input port: strobe sync, buffer, data register, match, pending.
module hip_input_port (
    input  wire logic                         MCLK_IN,
    input  wire logic                         RESET_N_IN,
    input  wire logic [hip_pkg::DATA_W-1:0]   PORT_DATA_IN,
    input  wire logic                         STROBE_IN_N_IN,
    output logic                              READY_FOR_BYTE_OUT,
    output logic                              DATA_ACCEPTED_OUT,
    input  wire logic [1:0]                   HS_MODE_IN,
    input  wire logic                         SINGLE_BUFFER_SEL_IN,
    input  wire logic                         TWO_BYTE_IRQ_SEL_IN,
    input  wire logic                         MATCH_ONLY_IRQ_IN,
    input  wire logic [1:0]                   MATCH_MODE_SEL_IN,
    input  wire logic [hip_pkg::DATA_W-1:0]   MATCH_VALUE_IN,
    input  wire logic [hip_pkg::DATA_W-1:0]   MATCH_MASK_IN,
    input  wire logic [hip_pkg::TC_W-1:0]     TIME_CONSTANT_IN,
    input  wire logic [1:0]                   TIMER_DUTY_IN,
    input  wire logic                         DATA_READ_IN,
    input  wire logic                         IRQ_CLEAR_IN,
    output logic [hip_pkg::DATA_W-1:0]        IN_DATA_OUT,
    output logic                              INPUT_FULL_FLAG_OUT,
    output logic                              MATCH_FLAG_OUT,
    output logic                              IRQ_PENDING_OUT
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    hip_pkg::hip_hs_mode_t           hs_mode;
    hip_pkg::hip_match_mode_t        match_mode;
    logic [2:0]                      strobe_s_r;
    logic                            strobe_lvl_r;
    logic [hip_pkg::DATA_W-1:0]      data_s1_r;
    logic [hip_pkg::DATA_W-1:0]      data_s2_r;
    logic [hip_pkg::DATA_W-1:0]      data_s3_r;
    logic [hip_pkg::DATA_W-1:0]      data_lvl_r;
    logic                            pin_fall;
    logic                            ack_lvl;
    logic                            ack_prev_r;
    logic                            ack_fall;
    logic [hip_pkg::DATA_W-1:0]      buf_r;
    logic                            buf_full_r;
    logic [hip_pkg::DATA_W-1:0]      idr_r;
    logic                            input_full_flag_r;
    logic                            match_flag_r;
    logic                            irq_pending_r;
    logic                            read_seen_r;
    logic                            ready_for_byte_r;
    logic                            data_accepted_r;
    logic                            capture;
    logic                            move;
    logic                            byte_match;
    logic                            match_on;
    logic                            rd;
    logic                            release_hold;
    logic                            empty_now;
    logic                            irq_set;
    logic                            irq_clr;
    logic                            ready_cond;

    hip_tmr_if tmr_bus ();

    assign hs_mode    = hip_pkg::hip_hs_mode_t'(HS_MODE_IN);
    assign match_mode = hip_pkg::hip_match_mode_t'(MATCH_MODE_SEL_IN);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Three flops per pin; a new level is accepted only when the second
    // and third agree, so a runt on the strobe makes no edge at all.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            strobe_s_r   <= hip_pkg::SYNC_RESET;
            strobe_lvl_r <= 1'b1;
        end else begin
            strobe_s_r <= {strobe_s_r[1:0], STROBE_IN_N_IN};
            if (strobe_s_r[1] == strobe_s_r[2]) begin
                strobe_lvl_r <= strobe_s_r[2];
            end
        end
    end

    // The data pins follow the same path, so they stay aligned with
    // the strobe that qualifies them.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            data_s1_r  <= '0;
            data_s2_r  <= '0;
            data_s3_r  <= '0;
            data_lvl_r <= '0;
        end else begin
            data_s1_r <= PORT_DATA_IN;
            data_s2_r <= data_s1_r;
            data_s3_r <= data_s2_r;
            if (data_s2_r == data_s3_r) begin
                data_lvl_r <= data_s3_r;
            end
        end
    end

    // One-cycle pulse when the accepted pin level turns low.
    assign pin_fall = strobe_lvl_r && (strobe_s_r[1] == strobe_s_r[2])
                      && !strobe_s_r[2];

    // ------------------------------------------------------------------
    // Acknowledge path and delay timer
    // ------------------------------------------------------------------
    // In pulsed mode the timer sits in the strobe path; its inverted
    // output stands in for the pin in all interlock decisions.
    assign tmr_bus.trigger       = pin_fall
                                   && (hs_mode == hip_pkg::HIP_HS_PULSED);
    assign tmr_bus.time_constant = TIME_CONSTANT_IN;
    assign tmr_bus.duty          = TIMER_DUTY_IN;
    assign ack_lvl = (hs_mode == hip_pkg::HIP_HS_PULSED)
                     ? tmr_bus.ack_int_n : strobe_lvl_r;

    hip_ack_timer u_timer (
        .clk_in   (MCLK_IN),
        .rst_n_in (RESET_N_IN),
        .tmr      (tmr_bus.tmr)
    );

    // Edge detector on the acknowledge actually in use.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ack_prev_r <= 1'b1;
        end else begin
            ack_prev_r <= ack_lvl;
        end
    end

    assign ack_fall = ack_prev_r && !ack_lvl;

    // ------------------------------------------------------------------
    // Pattern match
    // ------------------------------------------------------------------
    // The transition mode needs history that the register does not
    // keep, so it simply never matches here.
    assign match_on = (match_mode == hip_pkg::HIP_MATCH_AND)
                      || (match_mode == hip_pkg::HIP_MATCH_OR);

    always_comb begin
        logic [hip_pkg::DATA_W-1:0] eq;
        eq = ~(buf_r ^ MATCH_VALUE_IN) & MATCH_MASK_IN;
        unique case (match_mode)
            hip_pkg::HIP_MATCH_AND:
                byte_match = (eq == MATCH_MASK_IN);
            hip_pkg::HIP_MATCH_OR:
                byte_match = (eq != '0);
            hip_pkg::HIP_MATCH_OFF,
            hip_pkg::HIP_OR_TRANSITION:
                byte_match = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Event terms
    // ------------------------------------------------------------------
    // A strobe edge against a full buffer is a source error and is
    // dropped; the buffered byte is never overwritten.
    assign capture = ack_fall && !buf_full_r;
    assign move    = buf_full_r && !input_full_flag_r;
    assign rd      = DATA_READ_IN && input_full_flag_r;

    // A matched byte is held until both a read and a pending clear
    // have been seen, in either order.
    assign release_hold = input_full_flag_r && match_flag_r
                          && (rd || read_seen_r)
                          && (!irq_pending_r || IRQ_CLEAR_IN)
                          && !irq_set;
    assign empty_now = (rd && !match_flag_r) || release_hold;

    assign irq_set =
        (move && !TWO_BYTE_IRQ_SEL_IN
              && (!MATCH_ONLY_IRQ_IN || byte_match))
        || (move && TWO_BYTE_IRQ_SEL_IN && match_on
              && byte_match)
        || (capture && TWO_BYTE_IRQ_SEL_IN
              && input_full_flag_r);

    // In two-byte mode only the read that leaves nothing behind in the
    // buffer clears pending; a matched byte needs the clear command.
    assign irq_clr = IRQ_CLEAR_IN
                     || (rd && !match_flag_r
                         && (!TWO_BYTE_IRQ_SEL_IN || !buf_full_r));

    // ------------------------------------------------------------------
    // Buffer register
    // ------------------------------------------------------------------
    // Buffer and data register form the two-entry buffer: the strobe
    // side fills it, the read strobe drains it, and ready-for-byte is
    // the back-pressure toward the source.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            buf_r      <= '0;
            buf_full_r <= 1'b0;
        end else begin
            if (capture) begin
                buf_r      <= data_lvl_r;
                buf_full_r <= 1'b1;
            end else if (move && !SINGLE_BUFFER_SEL_IN) begin
                buf_full_r <= 1'b0;
            end else if (empty_now && SINGLE_BUFFER_SEL_IN) begin
                buf_full_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Input data register and flags
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            idr_r             <= '0;
            input_full_flag_r <= 1'b0;
            match_flag_r      <= 1'b0;
        end else begin
            if (move) begin
                idr_r             <= buf_r;
                input_full_flag_r <= 1'b1;
                match_flag_r      <= byte_match;
            end else if (empty_now) begin
                input_full_flag_r <= 1'b0;
            end
        end
    end

    // Remembers a read of a matched byte until the pending clear comes.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            read_seen_r <= 1'b0;
        end else begin
            if (move || release_hold) begin
                read_seen_r <= 1'b0;
            end else if (rd && match_flag_r) begin
                read_seen_r <= 1'b1;
            end
        end
    end

    // Pending: a set in the same cycle as a clear wins.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            irq_pending_r <= 1'b0;
        end else begin
            if (irq_set) begin
                irq_pending_r <= 1'b1;
            end else if (irq_clr) begin
                irq_pending_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Handshake outputs
    // ------------------------------------------------------------------
    // Strobed mode ignores the acknowledge level; the others wait for
    // it, which in pulsed mode gives a minimum low time for free.
    always_comb begin
        unique case (hs_mode)
            hip_pkg::HIP_HS_STROBED:
                ready_cond = !buf_full_r;
            hip_pkg::HIP_HS_PULSED:
                ready_cond = !buf_full_r && ack_lvl;
            hip_pkg::HIP_HS_THREE_WIRE:
                ready_cond = !buf_full_r && ack_lvl;
            hip_pkg::HIP_HS_INTERLOCKED:
                ready_cond = !buf_full_r && ack_lvl;
        endcase
    end

    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ready_for_byte_r <= hip_pkg::RFD_RESET;
        end else begin
            if (capture) begin
                ready_for_byte_r <= 1'b0;
            end else if (ready_cond) begin
                ready_for_byte_r <= 1'b1;
            end
        end
    end

    // Data-accepted only ever leaves low in three-wire mode.
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            data_accepted_r <= hip_pkg::DAC_RESET;
        end else begin
            if (hs_mode != hip_pkg::HIP_HS_THREE_WIRE) begin
                data_accepted_r <= 1'b0;
            end else if (capture) begin
                data_accepted_r <= 1'b1;
            end else if (strobe_lvl_r) begin
                data_accepted_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign READY_FOR_BYTE_OUT  = ready_for_byte_r;
    assign DATA_ACCEPTED_OUT   = data_accepted_r;
    assign IN_DATA_OUT         = idr_r;
    assign INPUT_FULL_FLAG_OUT = input_full_flag_r;
    assign MATCH_FLAG_OUT      = match_flag_r;
    assign IRQ_PENDING_OUT     = irq_pending_r;

endmodule

// ===== hip_input_port_sva.sv
// Checker for the handshake input port's pins and flags.
module hip_input_port_sva (
    input wire logic       MCLK_IN,
    input wire logic       RESET_N_IN,
    input wire logic       STROBE_IN_N_IN,
    input wire logic [1:0] HS_MODE_IN,
    input wire logic       SINGLE_BUFFER_SEL_IN,
    input wire logic       TWO_BYTE_IRQ_SEL_IN,
    input wire logic       MATCH_ONLY_IRQ_IN,
    input wire logic       DATA_READ_IN,
    input wire logic       IRQ_CLEAR_IN,
    input wire logic       READY_FOR_BYTE_OUT,
    input wire logic       DATA_ACCEPTED_OUT,
    input wire logic       INPUT_FULL_FLAG_OUT,
    input wire logic       MATCH_FLAG_OUT,
    input wire logic       IRQ_PENDING_OUT
);
    // Everything here lives on the one port clock.
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    a_pend_with_full: assert property (
        $rose(INPUT_FULL_FLAG_OUT) && !TWO_BYTE_IRQ_SEL_IN &&
        !MATCH_ONLY_IRQ_IN |-> IRQ_PENDING_OUT) else $error("no pending");
    a_read_clears: assert property (
        DATA_READ_IN && INPUT_FULL_FLAG_OUT && !MATCH_FLAG_OUT &&
        !TWO_BYTE_IRQ_SEL_IN |=> !INPUT_FULL_FLAG_OUT && !IRQ_PENDING_OUT)
        else $error("read did not clear");
    a_match_read_keeps: assert property (
        DATA_READ_IN && INPUT_FULL_FLAG_OUT && MATCH_FLAG_OUT &&
        IRQ_PENDING_OUT && !IRQ_CLEAR_IN
        |=> IRQ_PENDING_OUT && INPUT_FULL_FLAG_OUT) else $error("lost match");
    a_match_only_irq: assert property (
        MATCH_ONLY_IRQ_IN && $rose(IRQ_PENDING_OUT) |-> MATCH_FLAG_OUT)
        else $error("pending without match");
    a_ready_rise: assert property (
        $rose(READY_FOR_BYTE_OUT) && HS_MODE_IN inside {2'h0, 2'h3}
        |-> $past(STROBE_IN_N_IN, 3)) else $error("ready rose early");
    a_ready_fall: assert property (
        $fell(READY_FOR_BYTE_OUT) && HS_MODE_IN != 2'h2
        |-> !$past(STROBE_IN_N_IN, 3)) else $error("ready fell unasked");
    a_strobed_ready: assert property (
        $fell(READY_FOR_BYTE_OUT) && HS_MODE_IN == 2'h1 &&
        !SINGLE_BUFFER_SEL_IN && !INPUT_FULL_FLAG_OUT
        |-> ##[1:3] READY_FOR_BYTE_OUT) else $error("ready stuck low");
    a_accept_rise: assert property (
        $rose(DATA_ACCEPTED_OUT) |-> HS_MODE_IN == 2'h3
        ##[0:2] !READY_FOR_BYTE_OUT) else $error("bad accepted rise");
    a_accept_drop: assert property (
        STROBE_IN_N_IN [*6] |-> !DATA_ACCEPTED_OUT)
        else $error("accepted held");
endmodule

bind hip_input_port hip_input_port_sva u_sva (
    .MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN),
    .STROBE_IN_N_IN(STROBE_IN_N_IN), .HS_MODE_IN(HS_MODE_IN),
    .SINGLE_BUFFER_SEL_IN(SINGLE_BUFFER_SEL_IN),
    .TWO_BYTE_IRQ_SEL_IN(TWO_BYTE_IRQ_SEL_IN),
    .MATCH_ONLY_IRQ_IN(MATCH_ONLY_IRQ_IN), .DATA_READ_IN(DATA_READ_IN),
    .IRQ_CLEAR_IN(IRQ_CLEAR_IN), .READY_FOR_BYTE_OUT(READY_FOR_BYTE_OUT),
    .DATA_ACCEPTED_OUT(DATA_ACCEPTED_OUT),
    .INPUT_FULL_FLAG_OUT(INPUT_FULL_FLAG_OUT),
    .MATCH_FLAG_OUT(MATCH_FLAG_OUT), .IRQ_PENDING_OUT(IRQ_PENDING_OUT));

// ===== hip_input_port_tb.sv
// Self-checking testbench for the handshake input port.
module hip_input_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, stb_n, rdy, dac, full, mf, pend;
    logic tb2 = 1'b0, mo = 1'b0, rdi = 1'b0, cli = 1'b0, sb = 1'b0;
    logic [1:0] hs = 2'h0, mm = 2'h0, duty = 2'h0;
    logic [7:0] pdat, dout, mv = 8'h00;
    logic [15:0] tc = 16'h0020;
    logic [2:0] hx [3] = '{3'h0, 3'h2, 3'h1};
    int miscompares = 0, checked = 0, d, l;

    // The clock toggles every half period of 20 ns.
    always #20 clk = ~clk;

    hip_input_port dut (.MCLK_IN(clk), .RESET_N_IN(rst_n),
        .PORT_DATA_IN(pdat), .STROBE_IN_N_IN(stb_n),
        .READY_FOR_BYTE_OUT(rdy), .DATA_ACCEPTED_OUT(dac),
        .HS_MODE_IN(hs), .SINGLE_BUFFER_SEL_IN(sb),
        .TWO_BYTE_IRQ_SEL_IN(tb2), .MATCH_ONLY_IRQ_IN(mo),
        .MATCH_MODE_SEL_IN(mm), .MATCH_VALUE_IN(mv),
        .MATCH_MASK_IN(8'hFF), .TIME_CONSTANT_IN(tc),
        .TIMER_DUTY_IN(duty), .DATA_READ_IN(rdi), .IRQ_CLEAR_IN(cli),
        .IN_DATA_OUT(dout), .INPUT_FULL_FLAG_OUT(full),
        .MATCH_FLAG_OUT(mf), .IRQ_PENDING_OUT(pend));

    hip_src_model src (.clk_in(clk), .ready_in(rdy), .dac_in(dac),
        .mode_in(hs), .data_out(pdat), .strobe_n_out(stb_n));

    // Compares one value and reports a mismatch at once.
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask
    // Config inputs are static; every change is followed by a reset.
    task rst();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task put(input logic [7:0] b);
        src.send(b, 2);
        repeat (6) @(negedge clk);
    endtask
    // One-cycle pulses of the CPU read and of the clear command.
    task pls(input logic r, input logic c);
        @(negedge clk);
        rdi = r;
        cli = c;
        @(negedge clk);
        rdi = 1'b0;
        cli = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task conclude();
        miscompares += src.expired;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog sized well past the whole sequence.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end

    // Main sequence: match modes, two-byte, match-only, handshakes, timer.
    initial begin
        rst();
        chk({rdy, dac, full, pend}, 4'h8);
        mv = 8'h0F;
        for (int k = 0; k < 4; k++) begin
            mm = k[1:0];
            rst();
            put(8'h01);
            chk({dout, full}, 9'h003);
            chk({mf, pend}, {k == 2, 1'b1});
            pls(1'b1, 1'b0);
            chk({full, pend}, {2{k == 2}});
            pls(1'b0, 1'b1);
            chk({full, pend}, 2'h0);
        end
        tb2 = 1'b1;
        mm = 2'h0;
        rst();
        put(8'h11);
        chk({dout, pend}, 9'h022);
        put(8'h22);
        chk(pend, 1'b1);
        pls(1'b1, 1'b0);
        chk({dout, pend}, 9'h045);
        pls(1'b1, 1'b0);
        chk({full, pend}, 2'h0);
        mm = 2'h1;
        mv = 8'h5A;
        rst();
        put(8'h5A);
        chk({mf, pend}, 2'h3);
        pls(1'b1, 1'b0);
        pls(1'b0, 1'b1);
        chk(full, 1'b0);
        tb2 = 1'b0;
        mo = 1'b1;
        mv = 8'h77;
        rst();
        put(8'h12);
        chk({full, pend}, 2'h2);
        pls(1'b1, 1'b0);
        put(8'h77);
        chk({full, mf, pend}, 3'h7);
        mo = 1'b0;
        mm = 2'h0;
        sb = 1'b1;
        rst();
        put(8'h33);
        chk({rdy, full, pend}, 3'h3);
        pls(1'b1, 1'b0);
        chk({rdy, full, pend}, 3'h4);
        sb = 1'b0;
        for (int k = 0; k < 3; k++) begin
            hs = (k == 2) ? 2'h3 : k[1:0];
            rst();
            fork
                src.send(8'hC0, 20);
                begin
                    repeat (16) @(negedge clk);
                    chk({stb_n, rdy, dac}, hx[k]);
                end
            join
            repeat (6) @(negedge clk);
            chk({dac, dout}, 9'h0C0);
        end
        hs = 2'h2;
        for (int k = 0; k < 3; k++) begin
            duty = k[1:0];
            rst();
            fork
                src.send(8'h40, 0);
                begin
                    wait (stb_n === 1'b0);
                    d = 0;
                    l = 0;
                    while (rdy !== 1'b0 && d < 99) begin
                        @(negedge clk);
                        d++;
                    end
                    while (rdy !== 1'b1 && l < 99) begin
                        @(negedge clk);
                        l++;
                    end
                end
            join
            chk(d >= tc && d < 99, k != 1);
            chk(l >= tc && l < 99, k != 0);
            chk(dout, 8'h40);
        end
        conclude();
    end
endmodule

// ===== hip_pkg.sv
// Constants and types shared by the handshake input port and its timer.
package hip_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int        DATA_W       = 8;
    localparam int        TC_W         = 16;
    localparam logic      RFD_RESET    = 1'b1;
    localparam logic      DAC_RESET    = 1'b0;
    localparam logic [2:0] SYNC_RESET  = 3'h7;
    localparam logic [TC_W-1:0] TC_ONE = 16'h0001;

    // ------------------------------------------------------------------
    // Mode encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        HIP_HS_INTERLOCKED = 2'h0,
        HIP_HS_STROBED     = 2'h1,
        HIP_HS_PULSED      = 2'h2,
        HIP_HS_THREE_WIRE  = 2'h3
    } hip_hs_mode_t;

    typedef enum logic [1:0] {
        HIP_MATCH_OFF      = 2'h0,
        HIP_MATCH_AND      = 2'h1,
        HIP_MATCH_OR       = 2'h2,
        HIP_OR_TRANSITION  = 2'h3
    } hip_match_mode_t;

    typedef enum logic [1:0] {
        HIP_DUTY_PULSE     = 2'h0,
        HIP_DUTY_ONE_SHOT  = 2'h1,
        HIP_DUTY_SQUARE    = 2'h2
    } hip_duty_t;

    // Timer states, Gray coded along idle, delay, low.
    typedef enum logic [1:0] {
        HIP_TMR_IDLE  = 2'b00,
        HIP_TMR_DELAY = 2'b01,
        HIP_TMR_LOW   = 2'b11
    } hip_tmr_state_t;

endpackage

// ===== hip_src_model.sv
// Data source model that drives the port pins and the strobe.
module hip_src_model (
    input  wire logic       clk_in,
    input  wire logic       ready_in,
    input  wire logic       dac_in,
    input  wire logic [1:0] mode_in,
    output logic [7:0]      data_out,
    output logic            strobe_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Counts waits that ran out; the bench adds them to its mismatches.
    int expired = 0;
    initial begin
        data_out = 8'hFF;
        strobe_n_out = 1'b1;
    end
    // Sends one byte; hold sets how long the strobe stays low after the
    // answer, so a prompt and a slow source can both be played.
    task automatic send(input logic [7:0] b, input int hold);
        int n;
        n = 0;
        while (ready_in !== 1'b1 && n < 300) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 300) expired++;
        data_out = b;
        repeat (4) @(negedge clk_in);
        strobe_n_out = 1'b0;
        n = 0;
        while ((ready_in !== 1'b0 || (mode_in == 2'h3 && dac_in !== 1'b1))
               && n < 300) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 300) expired++;
        repeat (hold) @(negedge clk_in);
        strobe_n_out = 1'b1;
        repeat (4) @(negedge clk_in);
        data_out = ~b; // Released lines show a changed value.
    endtask
endmodule

// ===== hip_tmr_if.sv
// Interface between the handshake logic and the acknowledge delay timer.
interface hip_tmr_if;
    logic                       trigger;
    logic [hip_pkg::TC_W-1:0]   time_constant;
    logic [1:0]                 duty;
    logic                       ack_int_n;

    modport ctl (
        output trigger,
        output time_constant,
        output duty,
        input  ack_int_n
    );

    modport tmr (
        input  trigger,
        input  time_constant,
        input  duty,
        output ack_int_n
    );
endinterface
